/* File: rtl/ifc_filter_irq.sv */
// Purpose: Debounce 48 inputs and raise a change interrupt per bit.
// Assumes: Inputs synchronous to clk_sys; host keeps filter setting within range.
// Notes: A mask bit of 1 disables that input's interrupt.
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module ifc_filter_irq
	import ifc_pkg::*;
#(
	parameter int NBITS = IFC_NBITS
) (
	input wire logic clk_sys, // System clock, 20 MHz.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic [NBITS-1:0] pin_in, // Raw input levels, high reads 1.
	input wire logic [IFC_AW-1:0] reg_addr, // Register index.
	input wire logic [IFC_DW-1:0] reg_wdata, // Write data.
	input wire logic reg_wr, // Write strobe.
	input wire logic reg_rd, // Read strobe.
	output logic [IFC_DW-1:0] reg_rdata, // Read data, cycle after strobe.
	output logic [NBITS-1:0] data_in, // Conditioned input levels.
	output logic irq // Interrupt request.
);
	logic [IFC_FILT_W-1:0] filt_q;
	logic [NBITS-1:0] mask_q;
	logic [NBITS-1:0] edge_q;
	logic [NBITS-1:0] stat_q;
	logic [NBITS-1:0] filt_out_q;
	logic [NBITS-1:0] cond;
	logic [NBITS-1:0] prev_q;
	logic [NBITS-1:0] hit;
	logic [2:0] ph_q;
	logic tick;
	logic [IFC_CNT_W-1:0] limit;
	logic clr_lo;
	logic clr_hi;
	logic [IFC_DW-1:0] rdata_d;

	// Control registers; one filter setting serves every input, mask and edge select are per bit.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			filt_q <= IFC_FILT_RST;
			mask_q <= IFC_MASK_RST;
			edge_q <= IFC_EDGE_RST;
		end else if (reg_wr) begin
			unique case (reg_addr)
				IFC_REG_FILT: filt_q <= reg_wdata[IFC_FILT_W-1:0];
				IFC_REG_MASK_LO: mask_q[IFC_LO_W-1:0] <= reg_wdata;
				IFC_REG_MASK_HI: mask_q[NBITS-1:IFC_LO_W] <= reg_wdata[IFC_HI_W-1:0];
				IFC_REG_EDGE_LO: edge_q[IFC_LO_W-1:0] <= reg_wdata;
				IFC_REG_EDGE_HI: edge_q[NBITS-1:IFC_LO_W] <= reg_wdata[IFC_HI_W-1:0];
				default: ;
			endcase
		end
	end

	// 8 MHz sample tick: two ticks every five system clocks.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ph_q <= '0;
		end else if (ph_q + IFC_PH_STEP >= IFC_PH_WRAP) begin
			ph_q <= ph_q + IFC_PH_STEP - IFC_PH_WRAP;
		end else begin
			ph_q <= ph_q + IFC_PH_STEP;
		end
	end
	assign tick = (ph_q + IFC_PH_STEP >= IFC_PH_WRAP);

	// Stable-time threshold in sample ticks, 2^n.
	assign limit = IFC_CNT_W'(1) << filt_q;

	// Per-bit stability counters restart whenever the input matches the output.
	// Each bit keeps its own flop so that the output vector has one driver per bit.
	for (genvar i = 0; i < NBITS; i++) begin : g_bit
		logic [IFC_CNT_W-1:0] cnt_q;
		logic out_q;
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				cnt_q <= '0;
				out_q <= 1'b0;
			end else if (pin_in[i] == out_q) begin
				cnt_q <= '0;
			end else if (tick) begin
				if (cnt_q + IFC_CNT_W'(1) >= limit) begin
					out_q <= pin_in[i];
					cnt_q <= '0;
				end else begin
					cnt_q <= cnt_q + IFC_CNT_W'(1);
				end
			end
		end
		assign filt_out_q[i] = out_q;
	end

	assign cond = (filt_q == IFC_FILT_RST) ? pin_in : filt_out_q;
	assign data_in = cond;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			prev_q <= '0;
		end else begin
			prev_q <= cond;
		end
	end

	// Selected edge on each unmasked bit.
	assign hit = ~mask_q & ((~edge_q & cond & ~prev_q) | (edge_q & ~cond & prev_q));

	assign clr_lo = reg_rd && (reg_addr == IFC_REG_STAT_LO);
	assign clr_hi = reg_rd && (reg_addr == IFC_REG_STAT_HI);

	// A new event in the clearing cycle survives the clear.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stat_q <= '0;
		end else begin
			stat_q <= (stat_q & ~{{IFC_HI_W{clr_hi}}, {IFC_LO_W{clr_lo}}}) | hit;
		end
	end

	assign irq = |stat_q;

	always_comb begin
		rdata_d = '0;
		unique case (reg_addr)
			IFC_REG_FILT: rdata_d[IFC_FILT_W-1:0] = filt_q;
			IFC_REG_MASK_LO: rdata_d = mask_q[IFC_LO_W-1:0];
			IFC_REG_MASK_HI: rdata_d[IFC_HI_W-1:0] = mask_q[NBITS-1:IFC_LO_W];
			IFC_REG_EDGE_LO: rdata_d = edge_q[IFC_LO_W-1:0];
			IFC_REG_EDGE_HI: rdata_d[IFC_HI_W-1:0] = edge_q[NBITS-1:IFC_LO_W];
			IFC_REG_STAT_LO: rdata_d = stat_q[IFC_LO_W-1:0];
			IFC_REG_STAT_HI: rdata_d[IFC_HI_W-1:0] = stat_q[NBITS-1:IFC_LO_W];
			IFC_REG_DATA_LO: rdata_d = cond[IFC_LO_W-1:0];
			IFC_REG_DATA_HI: rdata_d[IFC_HI_W-1:0] = cond[NBITS-1:IFC_LO_W];
			default: rdata_d = '0;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= rdata_d;
		end else begin
			reg_rdata <= '0;
		end
	end

	// Reset values of every control and status register.
	reset_state_a: assert property (@(posedge clk_sys)
		rst |=> (filt_q == IFC_FILT_RST && mask_q == IFC_MASK_RST && stat_q == '0))
		else $error("Reset values wrong.");

	edge_reset_a: assert property (@(posedge clk_sys)
		rst |=> edge_q == IFC_EDGE_RST)
		else $error("Edge selects not cleared by reset.");

	stat_reset_a: assert property (@(posedge clk_sys)
		rst |=> (stat_q == '0 && !irq && reg_rdata == '0))
		else $error("Status or request not cleared by reset.");

	out_reset_a: assert property (@(posedge clk_sys)
		rst |=> filt_out_q == '0)
		else $error("Filter outputs not cleared by reset.");

	// Register writes land on the next clock.
	filt_write_a: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_wr && reg_addr == IFC_REG_FILT) |=> filt_q == $past(reg_wdata[IFC_FILT_W-1:0]))
		else $error("Filter setting write lost.");

	filt_range_a: assert property (@(posedge clk_sys) disable iff (rst)
		filt_q <= IFC_FILT_MAX)
		else $error("Filter setting out of range.");

	mask_write_a: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_wr && reg_addr == IFC_REG_MASK_LO) |=> mask_q[IFC_LO_W-1:0] == $past(reg_wdata))
		else $error("Low mask write lost.");

	mask_hi_write_a: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_wr && reg_addr == IFC_REG_MASK_HI) |=> mask_q[NBITS-1:IFC_LO_W] == $past(reg_wdata[IFC_HI_W-1:0]))
		else $error("High mask write lost.");

	edge_write_a: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_wr && reg_addr == IFC_REG_EDGE_LO) |=> edge_q[IFC_LO_W-1:0] == $past(reg_wdata))
		else $error("Low edge select write lost.");

	edge_hi_write_a: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_wr && reg_addr == IFC_REG_EDGE_HI) |=> edge_q[NBITS-1:IFC_LO_W] == $past(reg_wdata[IFC_HI_W-1:0]))
		else $error("High edge select write lost.");

	// Read data stand for one cycle only.
	stat_read_a: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_rd && reg_addr == IFC_REG_STAT_LO) |=> reg_rdata == $past(stat_q[IFC_LO_W-1:0]))
		else $error("Status read returned wrong data.");

	data_read_a: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_rd && reg_addr == IFC_REG_DATA_LO) |=> reg_rdata == $past(cond[IFC_LO_W-1:0]))
		else $error("Input read returned wrong data.");

	filt_read_a: assert property (@(posedge clk_sys) disable iff (rst)
		(reg_rd && reg_addr == IFC_REG_FILT) |=> reg_rdata == IFC_DW'($past(filt_q)))
		else $error("Filter setting read returned wrong data.");

	rdata_idle_a: assert property (@(posedge clk_sys) disable iff (rst)
		!reg_rd |=> reg_rdata == '0)
		else $error("Read data stood outside its cycle.");

	// Sample tick spacing gives two ticks in every five clocks.
	tick_gap_a: assert property (@(posedge clk_sys) disable iff (rst)
		tick |=> !tick)
		else $error("Sample ticks too close.");

	tick_due_a: assert property (@(posedge clk_sys) disable iff (rst)
		(!tick ##1 !tick) |=> tick)
		else $error("Sample tick late.");

	// Filter behaviour.
	filt_steady_a: assert property (@(posedge clk_sys) disable iff (rst)
		(filt_q != IFC_FILT_RST && !tick) |=> $stable(filt_out_q))
		else $error("Filter output moved between sample ticks.");

	filter_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
		(filt_q != IFC_FILT_RST && pin_in[0] == filt_out_q[0]) |=> $stable(filt_out_q[0]))
		else $error("Filter output changed without cause.");

	short_glitch_a: assert property (@(posedge clk_sys) disable iff (rst)
		(filt_q == 5'h02 && $changed(filt_out_q[0])) |-> $past(pin_in[0], 8) == filt_out_q[0])
		else $error("Filter passed a short level.");

	bypass_path_a: assert property (@(posedge clk_sys) disable iff (rst)
		(filt_q == IFC_FILT_RST) |-> data_in == pin_in)
		else $error("Bypass does not pass raw input.");

	data_filtered_a: assert property (@(posedge clk_sys) disable iff (rst)
		(filt_q != IFC_FILT_RST) |-> data_in == filt_out_q)
		else $error("Filtered path not used while filtering.");

	// Status flags and the request.
	masked_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
		(mask_q[0] && !stat_q[0]) |=> !stat_q[0])
		else $error("Masked bit set its status flag.");

	masked_hi_a: assert property (@(posedge clk_sys) disable iff (rst)
		(mask_q[IFC_LO_W] && !stat_q[IFC_LO_W]) |=> !stat_q[IFC_LO_W])
		else $error("Masked high bit set its status flag.");

	irq_follows_a: assert property (@(posedge clk_sys) disable iff (rst)
		irq == (stat_q != '0))
		else $error("Request differs from status.");

	rise_sets_a: assert property (@(posedge clk_sys) disable iff (rst)
		(!mask_q[0] && !edge_q[0] && cond[0] && !prev_q[0]) |=> stat_q[0])
		else $error("Rising edge missed.");

	fall_sets_a: assert property (@(posedge clk_sys) disable iff (rst)
		(!mask_q[0] && edge_q[0] && !cond[0] && prev_q[0]) |=> stat_q[0])
		else $error("Falling edge missed.");

	read_clears_a: assert property (@(posedge clk_sys) disable iff (rst)
		(clr_lo && !hit[0]) |=> !stat_q[0])
		else $error("Status not cleared by read.");

	hi_clears_a: assert property (@(posedge clk_sys) disable iff (rst)
		(clr_hi && !hit[IFC_LO_W]) |=> !stat_q[IFC_LO_W])
		else $error("High status not cleared by read.");

	stat_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
		(!hit[0] && !clr_lo) |=> $stable(stat_q[0]))
		else $error("Status flag moved without an event.");

	// Per-bit checks so that every input is covered, not only bit 0.
	for (genvar j = 0; j < NBITS; j++) begin : g_chk
		edge_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
			hit[j] |=> stat_q[j])
			else $error("Edge on a bit left its flag clear.");

		mask_block_a: assert property (@(posedge clk_sys) disable iff (rst)
			mask_q[j] |-> !hit[j])
			else $error("Masked bit produced an event.");

		rise_hit_a: assert property (@(posedge clk_sys) disable iff (rst)
			(!mask_q[j] && !edge_q[j] && cond[j] && !prev_q[j]) |-> hit[j])
			else $error("Rising edge gave no event.");

		fall_hit_a: assert property (@(posedge clk_sys) disable iff (rst)
			(!mask_q[j] && edge_q[j] && !cond[j] && prev_q[j]) |-> hit[j])
			else $error("Falling edge gave no event.");

		bit_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
			(filt_q != IFC_FILT_RST && pin_in[j] == filt_out_q[j]) |=> $stable(filt_out_q[j]))
			else $error("Filter bit changed without cause.");

		bit_follow_a: assert property (@(posedge clk_sys) disable iff (rst)
			(filt_q != IFC_FILT_RST && $changed(filt_out_q[j])) |-> filt_out_q[j] == $past(pin_in[j]))
			else $error("Filter bit took a level the pin did not hold.");
	end : g_chk

	irq_seen_c: cover property (@(posedge clk_sys) disable iff (rst) $rose(irq));
	read_clear_c: cover property (@(posedge clk_sys) disable iff (rst) clr_lo && irq ##1 !irq);
	filtered_c: cover property (@(posedge clk_sys) disable iff (rst) filt_q != IFC_FILT_RST && $changed(filt_out_q[0]));
	fall_seen_c: cover property (@(posedge clk_sys) disable iff (rst) edge_q[0] && hit[0]);
	glitch_drop_c: cover property (@(posedge clk_sys) disable iff (rst)
		filt_q != IFC_FILT_RST && pin_in[0] != filt_out_q[0] ##1 pin_in[0] == filt_out_q[0]);
endmodule : ifc_filter_irq

/* File: rtl/ifc_pkg.sv */
// Purpose: Constants for the 48-input filter and change-interrupt block.
// Assumes: 20 MHz system clock, filter time counted in 8 MHz sample ticks.
// Notes: Register offsets are word indices on the plain register port.
package ifc_pkg;
	localparam int IFC_NBITS = 48;
	localparam int IFC_AW = 4;
	localparam int IFC_DW = 32;
	localparam logic [IFC_AW-1:0] IFC_REG_FILT = 4'h0;
	localparam logic [IFC_AW-1:0] IFC_REG_MASK_LO = 4'h1;
	localparam logic [IFC_AW-1:0] IFC_REG_MASK_HI = 4'h2;
	localparam logic [IFC_AW-1:0] IFC_REG_EDGE_LO = 4'h3;
	localparam logic [IFC_AW-1:0] IFC_REG_EDGE_HI = 4'h4;
	localparam logic [IFC_AW-1:0] IFC_REG_STAT_LO = 4'h5;
	localparam logic [IFC_AW-1:0] IFC_REG_STAT_HI = 4'h6;
	localparam logic [IFC_AW-1:0] IFC_REG_DATA_LO = 4'h7;
	localparam logic [IFC_AW-1:0] IFC_REG_DATA_HI = 4'h8;
	localparam int IFC_LO_W = 32;
	localparam int IFC_HI_W = 16;
	localparam int IFC_FILT_W = 5;
	localparam logic [IFC_FILT_W-1:0] IFC_FILT_MAX = 5'h14;
	localparam logic [IFC_FILT_W-1:0] IFC_FILT_RST = 5'h00;
	localparam int IFC_CNT_W = 21;
	localparam int IFC_SYS_KHZ = 20000;
	localparam int IFC_SAMPLE_KHZ = 8000;
	// 8 MHz tick rate from a 20 MHz clock: accumulate 2 per clock, wrap at 5.
	localparam logic [2:0] IFC_PH_STEP = 3'h2;
	localparam logic [2:0] IFC_PH_WRAP = 3'(IFC_SYS_KHZ * int'(IFC_PH_STEP) / IFC_SAMPLE_KHZ);
	localparam logic [IFC_NBITS-1:0] IFC_MASK_RST = '1;
	localparam logic [IFC_NBITS-1:0] IFC_EDGE_RST = '0;
endpackage : ifc_pkg

/* File: tb/ifc_host.sv */
// Purpose: Host model that drives the register port.
// Assumes: Signals change just after a rising edge; one strobe per call.
// Notes: Filter settings above the top step are never sent.
`timescale 1ns/1ps
module ifc_host
	import ifc_pkg::*;
(
	input wire logic clk_sys, // System clock.
	output logic [IFC_AW-1:0] reg_addr = '0, // Register index.
	output logic [IFC_DW-1:0] reg_wdata = '0, // Write data.
	output logic reg_wr = 1'b0, // Write strobe.
	output logic reg_rd = 1'b0 // Read strobe.
);
	task automatic xfer(input logic w, input logic [IFC_AW-1:0] a, input logic [IFC_DW-1:0] d);
		if (w && a == IFC_REG_FILT && d > 32'(IFC_FILT_MAX)) return;
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
	endtask : xfer
endmodule : ifc_host

/* File: tb/ifc_filter_irq_tb.sv */
// Purpose: Self-checking bench for the filter and change interrupt.
// Assumes: Host model drives the register port; bench drives pins.
// Notes: Reads queue their expected data; a monitor compares.
`timescale 1ns/1ps
module ifc_filter_irq_tb
	import ifc_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic rd_d = 1'b0;
	logic [IFC_NBITS-1:0] pin_in = '0;
	logic [IFC_NBITS-1:0] data_in, p;
	logic [IFC_AW-1:0] reg_addr;
	logic [IFC_DW-1:0] reg_wdata, reg_rdata;
	logic reg_wr, reg_rd, irq;
	logic [IFC_DW-1:0] exp_q[$];
	int fail_count = 0;
	int n_compared = 0;
	int seed = 51;
	always #25 clk_sys = ~clk_sys;
	ifc_host host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
	ifc_filter_irq dut (.clk_sys(clk_sys), .rst(rst), .pin_in(pin_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .data_in(data_in), .irq(irq));
	task automatic chk(input logic [IFC_NBITS-1:0] e, input logic [IFC_NBITS-1:0] g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic rd(input logic [IFC_AW-1:0] a, input logic [IFC_DW-1:0] e);
		exp_q.push_back(e);
		host.xfer(1'b0, a, '0);
	endtask : rd
	task automatic tally_and_finish();
		$display("compared %0d, failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish
	// Read data stand only in the cycle after the strobe.
	always @(posedge clk_sys) begin
		rd_d <= reg_rd;
		if (rd_d === 1'b1) chk(48'(exp_q.pop_front()), 48'(reg_rdata));
	end
	initial begin
		#100000;
		fail_count++;
		$display("CHECK FAILED at %0t: timed out", $time);
		tally_and_finish();
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		rd(IFC_REG_FILT, 32'h0);
		rd(IFC_REG_MASK_LO, 32'hffffffff);
		rd(IFC_REG_MASK_HI, 32'h0000ffff);
		rd(IFC_REG_EDGE_LO, 32'h0);
		rd(IFC_REG_EDGE_HI, 32'h0);
		rd(IFC_REG_STAT_HI, 32'h0);
		rd(4'hf, 32'h0);
		$display("test reset done");
		p = {16'($random(seed)), 32'($random(seed))} | 48'h1;
		host.xfer(1'b1, IFC_REG_MASK_LO, 32'h0);
		host.xfer(1'b1, IFC_REG_MASK_HI, 32'h0);
		@(posedge clk_sys);
		pin_in <= p;
		rd(IFC_REG_DATA_HI, 32'(p[47:32]));
		#1 chk(48'h1, 48'(irq));
		rd(IFC_REG_STAT_LO, p[31:0]);
		rd(IFC_REG_STAT_HI, 32'(p[47:32]));
		#1 chk(48'h0, 48'(irq));
		$display("test raw edges done");
		host.xfer(1'b1, IFC_REG_MASK_HI, 32'h0000ffff);
		host.xfer(1'b1, IFC_REG_EDGE_LO, 32'hffffffff);
		host.xfer(1'b1, IFC_REG_EDGE_HI, 32'h0000ffff);
		@(posedge clk_sys);
		pin_in <= '0;
		rd(IFC_REG_STAT_LO, p[31:0]);
		rd(IFC_REG_STAT_HI, 32'h0);
		$display("test fall and mask done");
		host.xfer(1'b1, IFC_REG_EDGE_LO, 32'h0);
		host.xfer(1'b1, IFC_REG_FILT, 32'h14);
		rd(IFC_REG_FILT, 32'h14);
		host.xfer(1'b1, IFC_REG_FILT, 32'h2);
		host.xfer(1'b1, IFC_REG_FILT, 32'h15);
		@(posedge clk_sys);
		pin_in <= '1;
		repeat (5) @(posedge clk_sys);
		pin_in <= '0;
		repeat (20) @(posedge clk_sys);
		#1 chk(48'h0, data_in);
		rd(IFC_REG_STAT_LO, 32'h0);
		@(posedge clk_sys);
		pin_in <= '1;
		repeat (6) @(posedge clk_sys);
		#1 chk(48'h0, data_in);
		repeat (10) @(posedge clk_sys);
		#1 chk('1, data_in);
		rd(IFC_REG_STAT_LO, 32'hffffffff);
		rd(IFC_REG_DATA_HI, 32'h0000ffff);
		@(posedge clk_sys);
		#1 $display("test filter done");
		tally_and_finish();
	end
endmodule : ifc_filter_irq_tb
